/* File: design/ibc_ctl1_defs.vh */
// constants for the control-one slice of the two-wire bus controller
// assumes a 32-bit classic wishbone slave port with byte selects
`ifndef IBC_CTL1_DEFS_VH
`define IBC_CTL1_DEFS_VH

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define IBC_OFS_CONTROL_ONE 8'h00
`define IBC_OFS_SLICE_STATUS 8'h40

// ------------------------------------------------------------
// reset value and writable-bit mask
// ------------------------------------------------------------
`define IBC_RST_CONTROL_ONE 16'h0000
`define IBC_WRITABLE_MASK 16'hBFFB

// ------------------------------------------------------------
// control-one field positions
// ------------------------------------------------------------
`define IBC_B_ENABLE 0
`define IBC_B_PERSONALITY 1
`define IBC_B_ROLE 3
`define IBC_B_ARP_EN 4
`define IBC_B_CHK_UNIT 5
`define IBC_B_GEN_CALL 6
`define IBC_B_NO_STRETCH 7
`define IBC_B_START 8
`define IBC_B_STOP 9
`define IBC_B_ACK_EN 10
`define IBC_B_ACK_POS 11
`define IBC_B_CHK_XFER 12
`define IBC_B_ALERT 13
`define IBC_B_SOFT_RST 15

// ------------------------------------------------------------
// slice status field positions
// ------------------------------------------------------------
`define IBC_S_ENGAGED 0
`define IBC_S_BUS_BUSY 1
`define IBC_S_CHK_INVALID 2
`define IBC_S_STRETCHING 3
`define IBC_S_HELD_ACK 4

// ------------------------------------------------------------
// address answers
// ------------------------------------------------------------
`define IBC_ADDR_GEN_CALL 7'h00
`define IBC_ADDR_ALERT_RESP 7'h0C
`define IBC_ADDR_SMB_HOST 7'h08
`define IBC_ADDR_SMB_DEVICE 7'h61

`endif

/* File: design/ibc_sync.v */
// two-flop synchroniser for pin inputs, one stage pair per bit
// assumes the inputs are asynchronous to clk_i
module ibc_sync #(
   parameter WIDTH = 2
) (
   input wire clk_i,
   input wire rst_i,
   input wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);
   // ------------------------------------------------------------
   // per-bit stages
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
         reg stage_a;
         reg stage_b;
         // idle bus lines rest high, so reset to one
         always @(posedge clk_i) begin
            if (rst_i) begin
               stage_a <= 1'b1;
               stage_b <= 1'b1;
            end else begin
               stage_a <= async_i[g];
               stage_b <= stage_a;
            end
         end
         assign sync_o[g] = stage_b;
      end
   endgenerate
endmodule // ibc_sync

/* File: design/ibc_addr_match.v */
// decides whether a received 7-bit address is to be acknowledged
// assumes own address comes from the address register outside this slice
`include "ibc_ctl1_defs.vh"
module ibc_addr_match (
   input wire [6:0] rx_addr_i,
   input wire [6:0] own_addr_i,
   input wire general_call_enable_i,
   input wire smbus_personality_i,
   input wire smbus_role_i,
   input wire address_resolution_enable_i,
   input wire alert_assert_i,
   output reg hit_o
);
   // ------------------------------------------------------------
   // answer decision
   // ------------------------------------------------------------
   // smbus-only addresses are ignored in plain i2c personality
   always @* begin
      hit_o = (rx_addr_i == own_addr_i);
      if (rx_addr_i == `IBC_ADDR_GEN_CALL) begin
         hit_o = general_call_enable_i; // R17
      end else if (smbus_personality_i && rx_addr_i == `IBC_ADDR_ALERT_RESP) begin
         hit_o = alert_assert_i; // R4
      end else if (smbus_personality_i && address_resolution_enable_i) begin
         if (!smbus_role_i && rx_addr_i == `IBC_ADDR_SMB_DEVICE) begin
            hit_o = 1'b1; // R18
         end else if (smbus_role_i && rx_addr_i == `IBC_ADDR_SMB_HOST) begin
            hit_o = 1'b1; // R18
         end
      end
   end
endmodule // ibc_addr_match

/* File: design/ibc_ctl1.v */
// control-one register slice of the two-wire bus controller with its steering logic
// assumes the protocol engine runs on clk_i and gives one-cycle event pulses
//
// Operation
// (R1) control register at offset zero, every bit zero after reset
// (R2) soft-reset bit holds the controller in reset; software checks idle first
// (R3) software may soft-reset when busy is stuck without a stop
// (R4) alert bit drives alert pin low and acks alert response address
// (R5) checksum bit cleared after checksum byte, start, stop or disable
// (R6) arbitration loss marks the running checksum invalid
// (R7) ack position picks current or next byte for ack and checksum
// (R8) software uses ack position only for two-byte reception, set beforehand
// (R9) software clears ack enable only after address flag cleared
// (R10) software sets checksum after ack position during address stretch
// (R11) ack enable acks each received byte; cleared when disabled
// (R12) stop request: master sends stop, slave releases lines; cleared on stop
// (R13) smbus timeout sets stop request by hardware
// (R14) software avoids writing while start, stop or checksum bits pending
// (R15) start request makes a start; cleared when sent or disabled
// (R16) slave stretches clock while data not ready unless no-stretch set
// (R17) general call bit decides ack of address zero
// (R18) address resolution answers device or host address by role bit
// (R19) enable cleared mid-transfer finishes then clears all control bits; soft-reset bit 15 is kept
// (R20) master software never clears enable during communication
// (R21) reserved bits 14 and 2 written as zero
// (R22) bit 1 selects i2c or smbus; bit 5 switches checksum unit
// (R23) registers accept 16-bit and 32-bit accesses
`include "ibc_ctl1_defs.vh"
module ibc_ctl1 #(
   parameter ADDR_W = 8
) (
   input wire clk_i,
   input wire rst_i,
   // wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [ADDR_W-1:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   // pins
   input wire scl_i,
   input wire sda_i,
   output reg scl_o,
   output reg scl_oe_n_o,
   output reg alert_o,
   output reg alert_oe_n_o,
   // protocol engine side
   input wire master_mode_i,
   input wire comm_active_i,
   input wire start_sent_i,
   input wire chk_done_i,
   input wire timeout_i,
   input wire arb_lost_i,
   input wire byte_rx_i,
   input wire addr_valid_i,
   input wire [6:0] rx_addr_i,
   input wire [6:0] own_addr_i,
   input wire address_matched_flag_i,
   input wire byte_finished_flag_i,
   output reg core_reset_o,
   output reg core_enable_o,
   output reg smbus_mode_o,
   output reg chk_unit_on_o,
   output reg start_gen_o,
   output reg stop_gen_o,
   output reg release_lines_o,
   output reg ack_byte_o,
   output reg chk_byte_o,
   output reg chk_valid_o,
   output reg addr_ack_o
);
   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   reg [15:0] bus_control_one;
   reg [15:0] next_bus_control_one;
   reg held_ack;
   reg held_chk;
   reg chk_invalid;
   reg bus_busy;
   reg scl_prev;
   reg sda_prev;
   wire [1:0] pins_sync;
   wire scl_s;
   wire sda_s;
   wire start_seen;
   wire stop_seen;
   wire addr_hit;
   wire soft_rst;
   wire engaged;
   wire disabled_idle;
   wire wr_ctl;
   wire bus_req;
   wire stretch;
   wire [15:0] slice_status;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // address compare used by read and write decode
   function hit_reg;
      input [ADDR_W-1:0] a;
      input [7:0] ofs;
      begin
         hit_reg = ({8'h00, a} == {{ADDR_W{1'b0}}, ofs});
      end
   endfunction

   // merges write data into a 16-bit register under the two low selects
   function [15:0] lane_merge;
      input [15:0] cur;
      input [31:0] wd;
      input [3:0] sel;
      begin
         lane_merge = cur;
         if (sel[0]) begin
            lane_merge[7:0] = wd[7:0];
         end
         if (sel[1]) begin
            lane_merge[15:8] = wd[15:8];
         end
      end
   endfunction

   // ------------------------------------------------------------
   // pin synchronisers and line condition detect
   // ------------------------------------------------------------
   ibc_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i({sda_i, scl_i}),
      .sync_o(pins_sync)
   );
   assign scl_s = pins_sync[0];
   assign sda_s = pins_sync[1];

   // data edge while clock high marks start or stop
   assign start_seen = scl_s && scl_prev && sda_prev && !sda_s;
   assign stop_seen = scl_s && scl_prev && !sda_prev && sda_s;

   always @(posedge clk_i) begin
      if (rst_i) begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_prev <= scl_s;
         sda_prev <= sda_s;
      end
   end

   // ------------------------------------------------------------
   // address answer
   // ------------------------------------------------------------
   ibc_addr_match u_match (
      .rx_addr_i(rx_addr_i),
      .own_addr_i(own_addr_i),
      .general_call_enable_i(bus_control_one[`IBC_B_GEN_CALL]),
      .smbus_personality_i(bus_control_one[`IBC_B_PERSONALITY]),
      .smbus_role_i(bus_control_one[`IBC_B_ROLE]),
      .address_resolution_enable_i(bus_control_one[`IBC_B_ARP_EN]),
      .alert_assert_i(bus_control_one[`IBC_B_ALERT]),
      .hit_o(addr_hit)
   );

   // ------------------------------------------------------------
   // status terms
   // ------------------------------------------------------------
   assign soft_rst = bus_control_one[`IBC_B_SOFT_RST];
   // a cleared enable keeps the engine running until the transfer ends
   assign engaged = !soft_rst && (bus_control_one[`IBC_B_ENABLE] || comm_active_i); // R19
   assign disabled_idle = !bus_control_one[`IBC_B_ENABLE] && !comm_active_i;
   assign bus_req = cyc_i && stb_i && !ack_o;
   assign wr_ctl = bus_req && we_i && hit_reg(adr_i, `IBC_OFS_CONTROL_ONE);
   assign stretch = engaged && !master_mode_i && !bus_control_one[`IBC_B_NO_STRETCH] &&
                    (address_matched_flag_i || byte_finished_flag_i); // R16
   assign slice_status = {11'h000, held_ack, stretch, chk_invalid, bus_busy, engaged};

   // ------------------------------------------------------------
   // control register next value
   // ------------------------------------------------------------
   // order: hardware clears, then software write, then hardware sets,
   // so a set landing in the same cycle as a clear is kept
   always @* begin
      next_bus_control_one = bus_control_one;
      if (start_sent_i) begin
         next_bus_control_one[`IBC_B_START] = 1'b0; // R15
      end
      if (stop_seen) begin
         next_bus_control_one[`IBC_B_STOP] = 1'b0; // R12
      end
      if (chk_done_i || start_seen || stop_seen) begin
         next_bus_control_one[`IBC_B_CHK_XFER] = 1'b0; // R5
      end
      if (disabled_idle) begin
         // enable dropped and transfer over: everything but soft reset clears
         next_bus_control_one = bus_control_one & 16'h8000; // R19
         next_bus_control_one[`IBC_B_ALERT] = 1'b0; // R4
         next_bus_control_one[`IBC_B_CHK_XFER] = 1'b0; // R5
         next_bus_control_one[`IBC_B_ACK_POS] = 1'b0; // R7
         next_bus_control_one[`IBC_B_ACK_EN] = 1'b0; // R11
         next_bus_control_one[`IBC_B_START] = 1'b0; // R15
      end
      if (soft_rst) begin
         next_bus_control_one[`IBC_B_NO_STRETCH] = 1'b0; // R16
      end
      if (wr_ctl) begin
         // 16-bit or 32-bit access; reserved bits stay zero
         next_bus_control_one = lane_merge(next_bus_control_one, dat_i, sel_i)
                                & `IBC_WRITABLE_MASK; // R23
      end
      if (timeout_i && !soft_rst) begin
         next_bus_control_one[`IBC_B_STOP] = 1'b1; // R13
      end
   end

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         bus_control_one <= `IBC_RST_CONTROL_ONE; // R1
      end else begin
         bus_control_one <= next_bus_control_one;
      end
   end

   // ------------------------------------------------------------
   // wishbone answer
   // ------------------------------------------------------------
   // one wait state: ack comes the edge after the request is seen;
   // unmapped offsets still ack and read as zero, so no master hangs
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= bus_req;
         if (bus_req && !we_i) begin
            if (hit_reg(adr_i, `IBC_OFS_CONTROL_ONE)) begin
               dat_o <= {16'h0000, bus_control_one}; // R1
            end else if (hit_reg(adr_i, `IBC_OFS_SLICE_STATUS)) begin
               dat_o <= {16'h0000, slice_status};
            end else begin
               dat_o <= 32'h0000_0000;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // bus busy and checksum validity tracking
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i || soft_rst) begin
         bus_busy <= 1'b0; // R2
         chk_invalid <= 1'b0;
      end else begin
         if (start_seen) begin
            bus_busy <= 1'b1;
         end else if (stop_seen) begin
            bus_busy <= 1'b0;
         end
         // invalid until the next start restarts the calculation
         if (arb_lost_i) begin
            chk_invalid <= 1'b1; // R6
         end else if (start_seen) begin
            chk_invalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // ack and checksum position hold
   // ------------------------------------------------------------
   // with position set, the decision made now targets the following byte,
   // so the value at each byte end is held for the next one
   always @(posedge clk_i) begin
      if (rst_i || soft_rst) begin
         held_ack <= 1'b0;
         held_chk <= 1'b0;
      end else if (addr_valid_i || byte_rx_i) begin
         held_ack <= bus_control_one[`IBC_B_ACK_EN]; // R7
         held_chk <= bus_control_one[`IBC_B_CHK_XFER]; // R7
      end
   end

   // ------------------------------------------------------------
   // outputs to the engine
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         core_reset_o <= 1'b1;
         core_enable_o <= 1'b0;
         smbus_mode_o <= 1'b0;
         chk_unit_on_o <= 1'b0;
         start_gen_o <= 1'b0;
         stop_gen_o <= 1'b0;
         release_lines_o <= 1'b0;
         ack_byte_o <= 1'b0;
         chk_byte_o <= 1'b0;
         chk_valid_o <= 1'b0;
         addr_ack_o <= 1'b0;
      end else begin
         core_reset_o <= soft_rst; // R2
         core_enable_o <= engaged; // R19
         smbus_mode_o <= bus_control_one[`IBC_B_PERSONALITY]; // R22
         chk_unit_on_o <= bus_control_one[`IBC_B_CHK_UNIT]; // R22
         start_gen_o <= engaged && bus_control_one[`IBC_B_START]; // R15
         stop_gen_o <= engaged && master_mode_i && bus_control_one[`IBC_B_STOP]; // R12
         release_lines_o <= engaged && !master_mode_i && bus_control_one[`IBC_B_STOP]; // R12
         if (bus_control_one[`IBC_B_ACK_POS]) begin
            ack_byte_o <= engaged && held_ack; // R7
            chk_byte_o <= engaged && bus_control_one[`IBC_B_CHK_UNIT] && held_chk; // R7
         end else begin
            ack_byte_o <= engaged && bus_control_one[`IBC_B_ACK_EN]; // R11
            chk_byte_o <= engaged && bus_control_one[`IBC_B_CHK_UNIT] &&
                          bus_control_one[`IBC_B_CHK_XFER]; // R5
         end
         chk_valid_o <= bus_control_one[`IBC_B_CHK_UNIT] && !chk_invalid; // R6
         addr_ack_o <= engaged && addr_hit; // R17
      end
   end

   // ------------------------------------------------------------
   // pin drivers
   // ------------------------------------------------------------
   // open-drain: output data is always low, enable low means driving
   always @(posedge clk_i) begin
      if (rst_i) begin
         scl_o <= 1'b0;
         scl_oe_n_o <= 1'b1;
         alert_o <= 1'b0;
         alert_oe_n_o <= 1'b1;
      end else begin
         scl_o <= 1'b0;
         scl_oe_n_o <= !stretch; // R16
         alert_o <= 1'b0;
         alert_oe_n_o <= !bus_control_one[`IBC_B_ALERT]; // R4
      end
   end
endmodule // ibc_ctl1

/* File: tb/ibc_ctl1_properties.sv */
// checker for the control-one slice: bus answer and engine outputs
// assumes it is bound into ibc_ctl1 and sees only that module's ports
module ibc_ctl1_properties #(
   parameter ADDR_W = 8
) (
   input logic clk_i,
   input logic rst_i,
   input logic cyc_i,
   input logic stb_i,
   input logic we_i,
   input logic [ADDR_W-1:0] adr_i,
   input logic [3:0] sel_i,
   input logic [31:0] dat_i,
   input logic [31:0] dat_o,
   input logic ack_o,
   input logic scl_oe_n_o,
   input logic alert_oe_n_o,
   input logic master_mode_i,
   input logic comm_active_i,
   input logic timeout_i,
   input logic arb_lost_i,
   input logic address_matched_flag_i,
   input logic byte_finished_flag_i,
   input logic core_reset_o,
   input logic core_enable_o,
   input logic start_gen_o,
   input logic stop_gen_o,
   input logic release_lines_o,
   input logic chk_valid_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic take;
   logic rd_q;
   // a control register request is taken on an edge where ack is still low
   assign take = cyc_i && stb_i && !ack_o && adr_i == '0;
   // marks the cycle whose ack carries control register read data
   always_ff @(posedge clk_i) begin
      rd_q <= rst_i ? 1'b0 : take && !we_i;
   end
   sequence s_answer;
      ack_o ##1 !ack_o;
   endsequence
   sequence s_timeout;
      timeout_i && master_mode_i && comm_active_i ##1 master_mode_i && comm_active_i;
   endsequence
   a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> s_answer)
      else $error("bus request not answered by a single ack");
   a_soft_reset: assert property (take && we_i && sel_i[1] |-> ##2 core_reset_o == $past(dat_i[15], 2))
      else $error("core reset does not follow soft reset bit");
   a_alert_pin: assert property (rd_q |-> alert_oe_n_o == !dat_o[13])
      else $error("alert pin disagrees with alert bit");
   a_reserved_zero: assert property (rd_q |-> dat_o[14] == 1'b0 && dat_o[2] == 1'b0)
      else $error("reserved bit reads one");
   a_roles_apart: assert property (stop_gen_o |-> !release_lines_o && $past(master_mode_i))
      else $error("stop generated outside master role");
   a_timeout_stop: assert property (s_timeout ##0 !core_reset_o |=> stop_gen_o)
      else $error("timeout did not request a stop");
   a_arb_invalid: assert property (arb_lost_i |-> ##2 !chk_valid_o)
      else $error("checksum still valid after arbitration loss");
   a_stretch_cause: assert property (!scl_oe_n_o |-> $past(address_matched_flag_i
      || byte_finished_flag_i) && !$past(master_mode_i))
      else $error("clock stretched without a pending flag");
   a_start_engaged: assert property (start_gen_o |-> core_enable_o)
      else $error("start request while not engaged");
endmodule // ibc_ctl1_properties

bind ibc_ctl1 ibc_ctl1_properties #(.ADDR_W(ADDR_W)) ibc_ctl1_properties_inst (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
   .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .scl_oe_n_o(scl_oe_n_o),
   .alert_oe_n_o(alert_oe_n_o), .master_mode_i(master_mode_i), .comm_active_i(comm_active_i),
   .timeout_i(timeout_i), .arb_lost_i(arb_lost_i),
   .address_matched_flag_i(address_matched_flag_i), .byte_finished_flag_i(byte_finished_flag_i),
   .core_reset_o(core_reset_o), .core_enable_o(core_enable_o), .start_gen_o(start_gen_o),
   .stop_gen_o(stop_gen_o), .release_lines_o(release_lines_o), .chk_valid_o(chk_valid_o));

/* File: tb/ibc_bus_peer.sv */
// another device on the two-wire bus, making start and stop conditions
// assumes pull-ups on both lines; the clock stands still outside frames
module ibc_bus_peer (
   input logic clk_i,
   input logic scl_oe_n_i,
   output logic scl_o,
   output logic sda_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic scl_drv = 1'h1;
   logic sda_drv = 1'h1;
   // wired-and with the slice's stretch pull, released lines float high
   assign scl_o = scl_drv & scl_oe_n_i;
   assign sda_o = sda_drv;
   task automatic half;
      repeat (4) @(posedge clk_i);
   endtask
   // data falls while clock is high
   task automatic start_cond;
      sda_drv <= 1'h0;
      half;
   endtask
   // data rises while clock is high
   task automatic stop_cond;
      scl_drv <= 1'h0;
      half;
      scl_drv <= 1'h1;
      half;
      sda_drv <= 1'h1;
      half;
   endtask
endmodule // ibc_bus_peer

/* File: tb/tb_i2c_smbus_control_one.sv */
// self-checking bench for the control-one slice of the two-wire controller
// assumes the peer model and the checker are compiled before it
module tb_i2c_smbus_control_one;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, scl, sda, scl_oe_n;
   logic master = 0, comm = 0, addr_flag = 0, byte_flag = 0, alert_oe_n, core_rst;
   logic [5:0] ev = 6'h00;
   logic [6:0] rx = 7'h00;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0000_0000, rdat, r;
   logic smb, chk_on, st_g, sp_g, rel, ackb, chkv, aack, chkb, c_en;
   int n_errors = 0, check_count = 0;
   // 20 MHz clock
   always #25 clk = ~clk;
   ibc_ctl1 ibc_ctl1_inst (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .scl_i(scl),
      .sda_i(sda), .scl_o(), .scl_oe_n_o(scl_oe_n), .alert_o(), .alert_oe_n_o(alert_oe_n),
      .master_mode_i(master), .comm_active_i(comm), .start_sent_i(ev[0]), .chk_done_i(ev[1]),
      .timeout_i(ev[2]), .arb_lost_i(ev[3]), .byte_rx_i(ev[4]), .addr_valid_i(ev[5]),
      .rx_addr_i(rx), .own_addr_i(7'h2A), .address_matched_flag_i(addr_flag),
      .byte_finished_flag_i(byte_flag), .core_reset_o(core_rst), .core_enable_o(c_en),
      .smbus_mode_o(smb), .chk_unit_on_o(chk_on), .start_gen_o(st_g), .stop_gen_o(sp_g),
      .release_lines_o(rel), .ack_byte_o(ackb), .chk_byte_o(chkb), .chk_valid_o(chkv),
      .addr_ack_o(aack));
   ibc_bus_peer ibc_bus_peer_inst (.clk_i(clk), .scl_oe_n_i(scl_oe_n), .scl_o(scl), .sda_o(sda));
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic chk1(input logic seen, input logic exp);
      chk({31'h0, seen}, {31'h0, exp});
   endtask
   // one classic cycle; read data taken at the edge that sees ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= s;
      do @(posedge clk); while (ack !== 1'b1);
      r = rdat;
      cyc <= 0;
      stb <= 0;
      we <= 0;
   endtask
   task automatic wr(input logic [31:0] d);
      wb(1, 8'h00, d, 4'hF);
   endtask
   task automatic rd(input logic [7:0] a);
      wb(0, a, 32'h0000_0000, 4'hF);
   endtask
   task automatic pulse(input int b);
      @(posedge clk);
      ev[b] <= 1;
      @(posedge clk);
      ev[b] <= 0;
      @(posedge clk);
   endtask
   task automatic addr_try(input logic [6:0] a, input logic exp);
      rx <= a;
      pulse(5);
      @(negedge clk) chk1(aack, exp);
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset_map;
      rd(8'h00);
      chk(r, 32'h0000_0000);
      wb(1, 8'h20, 32'hFFFF_FFFF, 4'hF);
      rd(8'h20);
      chk(r, 32'h0000_0000);
      wr(32'h0000_4005);
      rd(8'h00);
      chk(r, 32'h0000_0001);
      wb(1, 8'h00, 32'hFFFF_EC00, 4'b0010);
      wb(1, 8'h00, 32'hFFFF_FFFF, 4'b1100);
      rd(8'h00);
      chk(r, 32'h0000_AC01);
   endtask
   task automatic t_disable;
      wr(32'h0000_2401);
      @(negedge clk) chk1(alert_oe_n, 1'b0);
      wb(1, 8'h00, 32'h0000_FF00, 4'b0001);
      rd(8'h00);
      chk(r, 32'h0000_0000);
      @(negedge clk) chk1(alert_oe_n, 1'b1);
   endtask
   task automatic t_start_stop;
      master <= 1;
      wr(32'h0000_0101);
      @(negedge clk) chk1(st_g, 1'b1);
      pulse(0);
      rd(8'h00);
      chk(r, 32'h0000_0001);
      wr(32'h0000_0201);
      @(negedge clk) chk1(sp_g, 1'b1);
      master <= 0;
      @(negedge clk) chk1(rel, 1'b1);
      ibc_bus_peer_inst.start_cond();
      rd(8'h40);
      chk(r & 32'h0000_0002, 32'h0000_0002);
      ibc_bus_peer_inst.stop_cond();
      rd(8'h00);
      chk(r, 32'h0000_0001);
   endtask
   task automatic t_checksum;
      wr(32'h0000_1021);
      @(negedge clk) chk({29'h0, smb, chk_on, chkv}, 32'h0000_0003);
      pulse(1);
      rd(8'h00);
      chk(r, 32'h0000_0021);
      pulse(3);
      @(negedge clk) chk1(chkv, 1'b0);
      wr(32'h0000_1023);
      @(negedge clk) chk1(smb, 1'b1);
      ibc_bus_peer_inst.start_cond();
      rd(8'h00);
      chk(r, 32'h0000_0023);
      chk1(chkv, 1'b1);
      ibc_bus_peer_inst.stop_cond();
   endtask
   task automatic t_timeout;
      master <= 1;
      comm <= 1;
      pulse(2);
      @(negedge clk) chk1(sp_g, 1'b1);
      ibc_bus_peer_inst.start_cond();
      ibc_bus_peer_inst.stop_cond();
      rd(8'h00);
      chk(r & 32'h0000_0200, 32'h0000_0000);
      @(posedge clk) master <= 0;
      wr(32'h0000_0400);
      @(negedge clk) chk1(c_en, 1'b1);
      @(posedge clk) comm <= 0;
      repeat (2) @(negedge clk);
      chk1(c_en, 1'b0);
      rd(8'h00);
      chk(r, 32'h0000_0000);
   endtask
   task automatic t_addresses;
      wr(32'h0000_0041);
      addr_try(7'h00, 1'b1);
      wr(32'h0000_0001);
      addr_try(7'h00, 1'b0);
      wr(32'h0000_0013);
      addr_try(7'h61, 1'b1);
      wr(32'h0000_001B);
      addr_try(7'h08, 1'b1);
      addr_try(7'h61, 1'b0);
      wr(32'h0000_2003);
      addr_try(7'h0C, 1'b1);
   endtask
   task automatic t_ack_pos;
      wr(32'h0000_0401);
      pulse(4);
      @(negedge clk) chk1(ackb, 1'b1);
      wr(32'h0000_0C21);
      wr(32'h0000_1C21);
      pulse(4);
      pulse(1);
      wr(32'h0000_0821);
      @(negedge clk) chk1(ackb, 1'b1);
      chk1(chkb, 1'b1);
      wr(32'h0000_0001);
      @(negedge clk) chk1(ackb, 1'b0);
      chk1(chkb, 1'b0);
   endtask
   task automatic t_stretch_soft;
      addr_flag <= 1;
      repeat (3) @(posedge clk);
      @(negedge clk) chk1(scl_oe_n, 1'b0);
      wr(32'h0000_0081);
      @(negedge clk) chk1(scl_oe_n, 1'b1);
      addr_flag <= 0;
      wr(32'h0000_8081);
      rd(8'h00);
      chk(r & 32'h0000_8080, 32'h0000_8000);
      chk1(core_rst, 1'b1);
      wr(32'h0000_0000);
      @(negedge clk) chk1(core_rst, 1'b0);
   endtask
   // main sequence: reset for 20 cycles, then every scenario
   initial begin
      repeat (20) @(posedge clk);
      rst <= 0;
      t_reset_map();
      t_disable();
      t_start_stop();
      t_checksum();
      t_timeout();
      t_addresses();
      t_ack_pos();
      t_stretch_soft();
      end_sim();
   end
   // watchdog: the scenarios need well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      end_sim();
   end
endmodule // tb_i2c_smbus_control_one
